// file: rtl/tsbm_top.sv
/*
 transport side of the shared slave bus: selection, status, motion flip-flops,
 write enable, write lock and motion-delay presets, with an APB register slave.
 assumes all slave-bus and sensor inputs are asynchronous to CLK.
*/
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
module tsbm_top #(
    parameter int SETTLE_CYC = tsbm_pkg::TSBM_SETTLE_CYC
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [7:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire tsbm_pkg::tsbm_bus_in_s SB_IN,
    input wire tsbm_pkg::tsbm_sense_s SENSE_IN,
    output tsbm_pkg::tsbm_bus_out_s SB_OUT,
    output logic SB_OE,
    output logic [13:0] PRESET_DATA,
    output logic PRESET_OE,
    output tsbm_pkg::tsbm_drive_s DRIVE_OUT
);
    import tsbm_pkg::*;

    localparam int SW = $bits(tsbm_bus_in_s) + $bits(tsbm_sense_s);

    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    tsbm_bus_in_s sb;
    tsbm_sense_s sn;
    wire [SW-1:0] pin_in = {SENSE_IN, SB_IN};

    // two-flop synchronisers on every slave-bus and sensor input
    genvar gi;
    generate
        for (gi = 0; gi < SW; gi = gi + 1) begin : g_sync
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= pin_in[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate
    assign sb = sync2[$bits(tsbm_bus_in_s)-1:0];
    assign sn = sync2[SW-1:$bits(tsbm_bus_in_s)];

    logic local_ff;
    logic [2:0] unit_plug_number;
    logic [13:0] preset_fwd;
    logic [13:0] preset_rev;
    logic [13:0] preset_bot;
    logic ahead_motion_ff;
    logic backward_motion_ff;
    logic rewind_status_ff;
    logic head_energize_ff;
    logic end_point_ff;
    logic lock_engaged;
    logic set_d;
    logic lp_d;
    logic rws_d;
    logic [31:0] settle_cnt;

    // attach on select match while on-line
    wire attached = !local_ff && (sb.sel == unit_plug_number);
    wire set_rise = sb.motion_set_pulse && !set_d;
    wire lp_rise = sn.load_point_mark && !lp_d;
    wire write_enabled = sn.ring_present || lock_engaged;
    wire write_locked = !write_enabled;
    // write on a locked reel refuses the whole command
    wire set_ev = set_rise && attached && sn.medium_loaded
        && !(sb.cmd_write && write_locked);
    wire go_local_pulse = set_ev && sb.cmd_write && sb.rewind_command_line;
    wire head_energize_set = set_ev && sb.cmd_write && !sb.rewind_command_line;
    // stop is ignored once rewinding; failure always halts
    wire motion_clear = (attached && sb.stop && !rewind_status_ff) || sn.failure;
    wire running = ahead_motion_ff || backward_motion_ff || rewind_status_ff || local_ff;
    wire settle_zero = (settle_cnt == 32'h0000_0000);
    wire settling = !running && !settle_zero;
    wire unit_ready = !running && settle_zero && sn.medium_loaded;
    wire rewind_done = rws_d && !rewind_status_ff;

    logic next_ahead;
    logic next_backward;
    logic next_rws;

    always_comb begin
        next_ahead = ahead_motion_ff;
        next_backward = backward_motion_ff;
        next_rws = rewind_status_ff;
        if (motion_clear) begin
            next_ahead = 1'b0;
            next_backward = 1'b0;
            next_rws = 1'b0;
        end else if (lp_rise && ahead_motion_ff) begin
            next_ahead = 1'b0;
            next_rws = 1'b0;
        end else if (lp_rise && rewind_status_ff) begin
            next_ahead = 1'b1;
        end else if (set_ev) begin
            if (sb.cmd_fwd) begin
                next_ahead = 1'b1;
            end
            if (sb.cmd_rev) begin
                next_backward = 1'b1;
            end
            if (sb.rewind_command_line && !sb.cmd_write && !sn.load_point_mark) begin
                next_rws = 1'b1;
            end
        end
    end

    // end marker only latches a flag, motion is left running
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ahead_motion_ff <= 1'b0;
            backward_motion_ff <= 1'b0;
            rewind_status_ff <= 1'b0;
            end_point_ff <= 1'b0;
            set_d <= 1'b0;
            lp_d <= 1'b0;
            rws_d <= 1'b0;
        end else begin
            ahead_motion_ff <= next_ahead;
            backward_motion_ff <= next_backward;
            rewind_status_ff <= next_rws;
            set_d <= sb.motion_set_pulse;
            lp_d <= sn.load_point_mark;
            rws_d <= rewind_status_ff;
            if (sn.end_mark) begin
                end_point_ff <= 1'b1;
            end else if (rewind_status_ff || backward_motion_ff) begin
                end_point_ff <= 1'b0;
            end
        end
    end

    // settle timer restarts while running, heads drop once motion has ceased and the settle count is zero
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            settle_cnt <= 32'h0000_0000;
            head_energize_ff <= 1'b0;
            lock_engaged <= 1'b0;
        end else begin
            if (running) begin
                settle_cnt <= 32'(SETTLE_CYC);
            end else if (!settle_zero) begin
                settle_cnt <= settle_cnt - 32'h0000_0001;
            end
            if (head_energize_set) begin
                head_energize_ff <= 1'b1;
            end else if (!running && settle_zero) begin
                head_energize_ff <= 1'b0;
            end
            lock_engaged <= sn.medium_loaded && (lock_engaged || sn.ring_present);
        end
    end

    // motion-delay preset, lowered by TSBM_EXT_GAP_CNT to lengthen the delay for an extended erase gap
    wire [13:0] base_preset = sb.cmd_rev ? preset_rev
        : (sn.load_point_mark ? preset_bot : preset_fwd);
    wire ext_gap = sb.cmd_erase && sb.cmd_fwd && !sn.load_point_mark;
    wire [13:0] preset_val = ext_gap ? base_preset - TSBM_EXT_GAP_CNT : base_preset;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            SB_OUT <= '0;
            SB_OE <= 1'b0;
            PRESET_DATA <= 14'h0000;
            PRESET_OE <= 1'b0;
            DRIVE_OUT <= '0;
        end else begin
            SB_OE <= attached;
            SB_OUT.seven_track_flag <= 1'b0;
            SB_OUT.load_point_flag <= attached && sn.load_point_mark;
            SB_OUT.end_point_flag <= attached && end_point_ff;
            SB_OUT.write_locked_flag <= attached && write_locked;
            SB_OUT.rewind_status_flag <= attached && rewind_status_ff;
            SB_OUT.settling_flag <= attached && settling;
            SB_OUT.unit_ready_flag <= attached && unit_ready;
            SB_OUT.unit_status_change <= attached && rewind_done;
            PRESET_OE <= attached && sb.delay_preset_enable;
            PRESET_DATA <= (attached && sb.delay_preset_enable) ? preset_val : 14'h0000;
            DRIVE_OUT.ahead <= ahead_motion_ff;
            DRIVE_OUT.backward <= backward_motion_ff || (rewind_status_ff && !ahead_motion_ff);
            DRIVE_OUT.rewinding <= rewind_status_ff;
            DRIVE_OUT.head_energize <= head_energize_ff;
            DRIVE_OUT.write_strobe_en <= attached && head_energize_ff && sb.speed_reached;
            DRIVE_OUT.lock_solenoid <= lock_engaged;
            DRIVE_OUT.select_lamp <= attached;
            DRIVE_OUT.off_line <= local_ff;
        end
    end

    // apb slave, zero wait states
    wire sel_ctrl = (PADDR == TSBM_CTRL_OFS);
    wire sel_stat = (PADDR == TSBM_STAT_OFS);
    wire sel_pfwd = (PADDR == TSBM_PFWD_OFS);
    wire sel_prev = (PADDR == TSBM_PREV_OFS);
    wire sel_pbot = (PADDR == TSBM_PBOT_OFS);
    wire mapped = sel_ctrl || sel_stat || sel_pfwd || sel_prev || sel_pbot;
    wire access = PSEL && PENABLE;
    wire wr = access && PWRITE && mapped;
    wire [31:0] ctrl_word = {25'h0, unit_plug_number, 3'h0, local_ff};
    wire [31:0] stat_word = {20'h0, attached, lock_engaged, head_energize_ff, unit_ready,
        settling, write_locked, end_point_ff, sn.load_point_mark, rewind_status_ff,
        backward_motion_ff, ahead_motion_ff, sn.medium_loaded};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_word
        : sel_stat ? stat_word
        : sel_pfwd ? {18'h0, preset_fwd}
        : sel_prev ? {18'h0, preset_rev}
        : sel_pbot ? {18'h0, preset_bot}
        : 32'h0000_0000;

    assign PREADY = 1'b1;
    assign PSLVERR = access && !mapped;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PRDATA <= 32'h0000_0000;
            local_ff <= TSBM_LOCAL_RST;
            unit_plug_number <= TSBM_UNIT_RST;
            preset_fwd <= TSBM_PRESET_RST;
            preset_rev <= TSBM_PRESET_RST;
            preset_bot <= TSBM_PRESET_RST;
        end else begin
            if (PSEL && !PENABLE) begin
                PRDATA <= rd_mux;
            end
            // hardware go-local wins over a software clear
            if (go_local_pulse) begin
                local_ff <= 1'b1;
            end else if (wr && sel_ctrl) begin
                local_ff <= PWDATA[TSBM_CTRL_LOCAL_BIT];
            end
            if (wr && sel_ctrl) begin
                unit_plug_number <= PWDATA[TSBM_CTRL_UNIT_LSB +: 3];
            end
            if (wr && sel_pfwd) begin
                preset_fwd <= PWDATA[TSBM_PRESET_W-1:0];
            end
            if (wr && sel_prev) begin
                preset_rev <= PWDATA[TSBM_PRESET_W-1:0];
            end
            if (wr && sel_pbot) begin
                preset_bot <= PWDATA[TSBM_PRESET_W-1:0];
            end
        end
    end

    a_eot_keeps_moving: assert property (@(posedge CLK) disable iff (!ARST_N)
        ahead_motion_ff && !motion_clear && !lp_rise |=> ahead_motion_ff)
        else $error("forward motion stopped without stop or load point");
    a_lp_no_rewind: assert property (@(posedge CLK) disable iff (!ARST_N)
        set_ev && sb.rewind_command_line && sn.load_point_mark && !rewind_status_ff
        |=> !rewind_status_ff)
        else $error("rewind accepted at load point");
    a_rewind_turns: assert property (@(posedge CLK) disable iff (!ARST_N)
        rewind_status_ff && !ahead_motion_ff && lp_rise && !motion_clear
        |=> ahead_motion_ff && rewind_status_ff)
        else $error("rewind into load point did not set forward");
    a_fwd_lp_clear: assert property (@(posedge CLK) disable iff (!ARST_N)
        ahead_motion_ff && lp_rise |=> !ahead_motion_ff && !rewind_status_ff)
        else $error("forward onto load point not cleared");
    a_lp_status: assert property (@(posedge CLK) disable iff (!ARST_N)
        ##1 SB_OUT.load_point_flag == $past(attached && sn.load_point_mark))
        else $error("load point status wrong");
    a_wlock_refuse: assert property (@(posedge CLK) disable iff (!ARST_N)
        $rose(head_energize_ff) |-> $past(write_enabled))
        else $error("heads energized on a locked reel");
    a_detached_quiet: assert property (@(posedge CLK) disable iff (!ARST_N)
        !attached |=> !SB_OE && !PRESET_OE && SB_OUT == '0)
        else $error("unattached unit drives the bus");
    a_ready_idle: assert property (@(posedge CLK) disable iff (!ARST_N)
        SB_OUT.unit_ready_flag |-> !SB_OUT.settling_flag && $past(!running && settle_zero))
        else $error("ready while busy or settling");
    a_rewind_ignores: assert property (@(posedge CLK) disable iff (!ARST_N)
        rewind_status_ff && sb.stop && !sn.failure && !lp_rise |=> rewind_status_ff)
        else $error("stop ended a rewind");
    a_motion_clear: assert property (@(posedge CLK) disable iff (!ARST_N)
        motion_clear |=> !ahead_motion_ff && !backward_motion_ff && !rewind_status_ff)
        else $error("motion clear left a motion flip-flop set");
endmodule

// file: rtl/tsbm_pkg.sv
/*
 package of the transport slave-bus motion block: register map, resets,
 timing counts and the carrier structs. assumes a 200 MHz system clock.
*/
// Contract
// - no self stop at end marker on-line
// - load point blocks new rewind commands
// - rewind reaching load point sets forward
// - forward onto load point clears forward, rewind
// - load point status only when attached
// - no ring: refuse writes, report write lock
// - solenoid holds write enable until unload
// - one controller, eight units, one attached
// - three-bit select code matched to plug number
// - unattached unit drives nothing, ignores bus
// - seven-track low, end point, rewind status
// - ready only when idle and not settling
// - set pulse sets forward, reverse or rewind
// - write plus rewind off-line, write energizes heads
// - presets driven while delay preset enabled
// - erase forward off load point extends 80 ms
// - speed reached enables write strobe
// - motion continues until stop or failure
// - rewind ignores stop, flags status change
// - motion clear resets all motion flip-flops
// - ready only while tape is loaded
package tsbm_pkg;
    localparam logic [7:0] TSBM_CTRL_OFS = 8'h00;
    localparam logic [7:0] TSBM_STAT_OFS = 8'h04;
    localparam logic [7:0] TSBM_PFWD_OFS = 8'h08;
    localparam logic [7:0] TSBM_PREV_OFS = 8'h0C;
    localparam logic [7:0] TSBM_PBOT_OFS = 8'h10;
    localparam int TSBM_CTRL_LOCAL_BIT = 0;
    localparam int TSBM_CTRL_UNIT_LSB = 4;
    localparam int TSBM_PRESET_W = 14;
    localparam logic TSBM_LOCAL_RST = 1'b1;
    localparam logic [2:0] TSBM_UNIT_RST = 3'h0;
    localparam logic [13:0] TSBM_PRESET_RST = 14'h0000;
    localparam real TSBM_CLK_NS = 5.0;
    localparam real TSBM_SETTLE_MS = 13.5;
    localparam int TSBM_SETTLE_CYC = $rtoi(TSBM_SETTLE_MS * 1.0e6 / TSBM_CLK_NS);
    localparam real TSBM_EXT_GAP_MS = 80.0;
    localparam real TSBM_BPI_CLK_KHZ = 36.0;
    localparam logic [13:0] TSBM_EXT_GAP_CNT = 14'($rtoi(TSBM_EXT_GAP_MS * TSBM_BPI_CLK_KHZ));

    typedef struct packed {
        logic [2:0] sel;
        logic motion_set_pulse;
        logic cmd_fwd;
        logic cmd_rev;
        logic rewind_command_line;
        logic cmd_write;
        logic cmd_erase;
        logic stop;
        logic delay_preset_enable;
        logic speed_reached;
    } tsbm_bus_in_s;

    typedef struct packed {
        logic load_point_mark;
        logic end_mark;
        logic ring_present;
        logic medium_loaded;
        logic failure;
    } tsbm_sense_s;

    typedef struct packed {
        logic seven_track_flag;
        logic load_point_flag;
        logic end_point_flag;
        logic write_locked_flag;
        logic rewind_status_flag;
        logic settling_flag;
        logic unit_ready_flag;
        logic unit_status_change;
    } tsbm_bus_out_s;

    typedef struct packed {
        logic ahead;
        logic backward;
        logic rewinding;
        logic head_energize;
        logic write_strobe_en;
        logic lock_solenoid;
        logic select_lamp;
        logic off_line;
    } tsbm_drive_s;
endpackage

// file: sim/tsbm_ctrl_model.sv
/*
 controller model on the slave bus: drive-go sequence and motion-delay counter.
 assumes the command template is set at least two cycles before go.
*/
`timescale 1ns/100ps
module tsbm_ctrl_model
    import tsbm_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic go,
    input wire logic stop_req,
    input wire tsbm_pkg::tsbm_bus_in_s cmd,
    input wire logic [13:0] preset_data,
    input wire logic preset_oe,
    output tsbm_pkg::tsbm_bus_in_s bus
);
    logic [3:0] seq;
    logic pulse;
    logic stop;
    logic dpe;
    logic [14:0] cnt;
    logic counting;
    logic [13:0] held;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seq <= 4'h0;
            pulse <= 1'b0;
            stop <= 1'b1;
            dpe <= 1'b0;
            cnt <= 15'h0;
            counting <= 1'b0;
            held <= 14'h0;
        end else begin
            if (go) begin
                seq <= 4'h1;
                stop <= 1'b0;
                dpe <= 1'b1;
                counting <= 1'b0;
            end else if (seq != 4'h0) begin
                seq <= seq + 4'h1;
            end
            pulse <= (seq >= 4'h2) && (seq <= 4'h4);
            if (preset_oe && dpe) held <= preset_data;
            if (seq == 4'h6 && cmd.rewind_command_line) stop <= 1'b1;
            if (seq == 4'hA) begin
                seq <= 4'h0;
                dpe <= 1'b0;
                cnt <= {1'b0, held};
                counting <= 1'b1;
            end else if (counting && !cnt[14]) begin
                cnt <= cnt + 15'h1;
            end
            if (stop_req) begin
                stop <= 1'b1;
                counting <= 1'b0;
            end
        end
    end
    // one unit code at a time on the shared select lines
    always_comb begin
        bus = cmd;
        bus.motion_set_pulse = pulse;
        bus.stop = stop;
        bus.delay_preset_enable = dpe;
        bus.speed_reached = counting && cnt[14];
    end
endmodule

// file: sim/testbench.sv
/*
 self-checking bench of the slave-bus motion block with a controller model.
 assumes zero-wait APB and a shortened settling count.
*/
`timescale 1ns/100ps
module testbench;
    import tsbm_pkg::*;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr, sb_oe, preset_oe, go, stop_req;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [13:0] preset_data, seen;
    logic err;
    tsbm_bus_in_s cmd, bus_in;
    tsbm_sense_s sense;
    tsbm_bus_out_s sb_out;
    tsbm_drive_s drv;
    int failures = 0;
    int compares = 0;
    tsbm_top #(.SETTLE_CYC(20)) dut (.CLK(clk), .ARST_N(arst_n), .PADDR(paddr), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SB_IN(bus_in), .SENSE_IN(sense), .SB_OUT(sb_out), .SB_OE(sb_oe),
        .PRESET_DATA(preset_data), .PRESET_OE(preset_oe), .DRIVE_OUT(drv));
    tsbm_ctrl_model ctl (.clk(clk), .arst_n(arst_n), .go(go), .stop_req(stop_req), .cmd(cmd),
        .preset_data(preset_data), .preset_oe(preset_oe), .bus(bus_in));
    task automatic wrap_up;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n == 20) begin
            failures++;
            wrap_up();
        end
    endtask
    task automatic motion(input logic f, input logic rw, input logic w, input logic e);
        cmd.cmd_fwd <= f;
        cmd.rewind_command_line <= rw;
        cmd.cmd_write <= w;
        cmd.cmd_erase <= e;
        cyc(3);
        go <= 1'b1;
        cyc(1);
        go <= 1'b0;
        repeat (16) begin
            @(posedge clk);
            if (preset_oe === 1'b1) seen = preset_data;
        end
    endtask
    task automatic halt;
        stop_req <= 1'b1;
        cyc(1);
        stop_req <= 1'b0;
        cyc(6);
    endtask
    task automatic wait_on(input bit rdy);
        int n;
        for (n = 0; n < 4000; n++) begin
            if (rdy ? sb_out.unit_ready_flag === 1'b1 : bus_in.speed_reached === 1'b1) break;
            @(posedge clk);
        end
        if (n == 4000) begin
            failures++;
            wrap_up();
        end
    endtask
    task automatic t_regs;
        apb(1'b0, TSBM_CTRL_OFS, 32'h0);
        chk32("ctrl reset", 32'h0000_0001, rd);
        apb(1'b0, 8'hFC, 32'h0);
        chk1("unmapped err", 1'b1, err);
        apb(1'b1, TSBM_PFWD_OFS, 32'h0000_3FC0);
        apb(1'b0, TSBM_PFWD_OFS, 32'h0);
        chk32("preset fwd", 32'h0000_3FC0, rd);
        apb(1'b1, TSBM_CTRL_OFS, 32'h0000_0030);
        $display("test regs done");
    endtask
    task automatic t_select;
        sense <= '{load_point_mark: 1'b1, end_mark: 1'b0, ring_present: 1'b1,
            medium_loaded: 1'b1, failure: 1'b0};
        cmd.sel <= 3'h5;
        cyc(8);
        chk1("oe other", 1'b0, sb_oe);
        chk1("lp other", 1'b0, sb_out.load_point_flag);
        cmd.sel <= 3'h3;
        cyc(8);
        chk1("oe own", 1'b1, sb_oe);
        chk1("lamp", 1'b1, drv.select_lamp);
        chk1("lp own", 1'b1, sb_out.load_point_flag);
        chk1("seven", 1'b0, sb_out.seven_track_flag);
        wait_on(1'b1);
        chk1("ready", 1'b1, sb_out.unit_ready_flag);
        apb(1'b0, TSBM_STAT_OFS, 32'h0);
        chk32("status", 32'h0000_0D11, rd);
        $display("test select done");
    endtask
    task automatic t_fwd;
        sense.load_point_mark <= 1'b0;
        motion(1'b1, 1'b0, 1'b0, 1'b0);
        chk32("preset", 32'h0000_3FC0, {18'h0, seen});
        chk1("ahead", 1'b1, drv.ahead);
        chk1("busy", 1'b0, sb_out.unit_ready_flag);
        wait_on(1'b0);
        sense.end_mark <= 1'b1;
        cyc(8);
        chk1("end pt", 1'b1, sb_out.end_point_flag);
        chk1("past end", 1'b1, drv.ahead);
        halt();
        chk1("stopped", 1'b0, drv.ahead);
        chk1("settling", 1'b1, sb_out.settling_flag);
        wait_on(1'b1);
        chk1("settled", 1'b0, sb_out.settling_flag);
        sense.end_mark <= 1'b0;
        $display("test forward done");
    endtask
    task automatic t_reverse;
        apb(1'b1, TSBM_PREV_OFS, 32'h0000_3F00);
        apb(1'b1, TSBM_PBOT_OFS, 32'h0000_3E00);
        cmd.cmd_rev <= 1'b1;
        motion(1'b0, 1'b0, 1'b0, 1'b0);
        chk32("rev preset", 32'h0000_3F00, {18'h0, seen});
        chk1("backward", 1'b1, drv.backward);
        chk1("end clr", 1'b0, sb_out.end_point_flag);
        sense.failure <= 1'b1;
        cyc(8);
        chk1("failed", 1'b0, drv.backward);
        sense.failure <= 1'b0;
        cmd.cmd_rev <= 1'b0;
        halt();
        wait_on(1'b1);
        $display("test reverse done");
    endtask
    task automatic t_write;
        motion(1'b1, 1'b0, 1'b1, 1'b1);
        chk32("gap preset", 32'h0000_3480, {18'h0, seen});
        chk1("heads", 1'b1, drv.head_energize);
        wait_on(1'b0);
        cyc(6);
        chk1("strobe", 1'b1, drv.write_strobe_en);
        halt();
        wait_on(1'b1);
        chk1("lock on", 1'b1, drv.lock_solenoid);
        sense.ring_present <= 1'b0;
        cyc(8);
        chk1("lock hold", 1'b0, sb_out.write_locked_flag);
        sense.medium_loaded <= 1'b0;
        cyc(8);
        chk1("lock off", 1'b0, drv.lock_solenoid);
        chk1("unloaded", 1'b0, sb_out.unit_ready_flag);
        $display("test write done");
    endtask
    task automatic t_locked;
        sense.medium_loaded <= 1'b1;
        cyc(30);
        chk1("wr lock", 1'b1, sb_out.write_locked_flag);
        motion(1'b1, 1'b0, 1'b1, 1'b0);
        chk1("refused", 1'b0, drv.ahead);
        chk1("no heads", 1'b0, drv.head_energize);
        halt();
        sense.ring_present <= 1'b1;
        $display("test locked done");
    endtask
    task automatic t_rewind;
        bit pulse_seen;
        pulse_seen = 1'b0;
        sense.load_point_mark <= 1'b1;
        motion(1'b0, 1'b1, 1'b0, 1'b0);
        chk32("bot preset", 32'h0000_3E00, {18'h0, seen});
        chk1("rew at lp", 1'b0, drv.rewinding);
        sense.load_point_mark <= 1'b0;
        motion(1'b0, 1'b1, 1'b0, 1'b0);
        chk1("rewinding", 1'b1, drv.rewinding);
        chk1("rws flag", 1'b1, sb_out.rewind_status_flag);
        chk1("rew back", 1'b1, drv.backward);
        sense.load_point_mark <= 1'b1;
        cyc(8);
        chk1("turn", 1'b1, drv.ahead);
        sense.load_point_mark <= 1'b0;
        cyc(6);
        sense.load_point_mark <= 1'b1;
        repeat (12) begin
            @(posedge clk);
            if (sb_out.unit_status_change === 1'b1) pulse_seen = 1'b1;
        end
        chk1("ssc", 1'b1, pulse_seen);
        chk1("rew end", 1'b0, drv.rewinding);
        chk1("fwd end", 1'b0, drv.ahead);
        $display("test rewind done");
    endtask
    task automatic t_offline;
        sense.load_point_mark <= 1'b0;
        wait_on(1'b1);
        motion(1'b0, 1'b1, 1'b1, 1'b0);
        chk1("local", 1'b1, drv.off_line);
        chk1("no rew", 1'b0, drv.rewinding);
        chk1("released", 1'b0, sb_oe);
        apb(1'b0, TSBM_CTRL_OFS, 32'h0);
        chk32("ctrl local", 32'h0000_0031, rd);
        $display("test offline done");
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #400000;
        failures++;
        wrap_up();
    end
    initial begin
        arst_n = 1'b0;
        {psel, penable, pwrite, go, stop_req} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cmd = '0;
        sense = '0;
        cyc(12);
        arst_n <= 1'b1;
        cyc(2);
        t_regs();
        t_select();
        t_fwd();
        t_reverse();
        t_write();
        t_locked();
        t_rewind();
        t_offline();
        wrap_up();
    end
endmodule
